// >>> hdl/low_voltage_status_logic.sv
`timescale 1ns/1ps
// How it works
// - flag sets on falling-trip report, clears on rising-trip report
// - between thresholds the flag keeps its previous value
// - any system reset forces the flag to zero
// - flag is readable even when reset generation is disabled
// - no interrupt request is ever raised
// - monitoring continues in wait mode; enabled reset wakes from wait
// - active in stop only with power-down clear and stop-enable set
// - active in stop with reset enabled issues a waking reset
module low_voltage_status_logic
    import lv_status_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_b_in,
    // analog comparators
    input  wire logic                  below_falling_trip_in,
    input  wire logic                  above_rising_trip_in,
    // supervisor reset request and monitor active status
    output logic                       supervisor_reset_out,
    output logic                       supervisor_active_out,
    // axi4-lite write address
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    // axi4-lite write data
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    // axi4-lite write response
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    // axi4-lite read address
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    // axi4-lite read data
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  flag;
        logic                  rst_req;
        logic [3:0]            cfg;
        logic [1:0]            ctl;
        logic                  aw_held;
        logic [ADDR_WIDTH-1:0] aw_addr;
        logic                  w_held;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } lv_state_t;

    lv_state_t state_q;
    lv_state_t state_d;

    // reset image: flag and handshakes clear, configuration at its defaults
    localparam lv_state_t STATE_RESET = '{
        flag:    1'b0,
        rst_req: 1'b0,
        cfg:     CONFIG_RESET,
        ctl:     CONTROL_RESET,
        aw_held: 1'b0,
        aw_addr: '0,
        w_held:  1'b0,
        w_data:  '0,
        w_strb:  '0,
        bvalid:  1'b0,
        bresp:   RESP_OKAY,
        rvalid:  1'b0,
        rdata:   '0,
        rresp:   RESP_OKAY
    };

    logic below_sync;
    logic above_sync;

    // ------------------------------------------------------------
    // comparator synchronisers
    // ------------------------------------------------------------
    // analog outputs move at any time; two stages keep a metastable sample off the flag
    localparam int TRIP_BELOW = 0;
    localparam int TRIP_ABOVE = 1;
    localparam int TRIP_COUNT = 2;

    logic [TRIP_COUNT-1:0] trip_raw;
    logic [TRIP_COUNT-1:0] trip_sync;

    assign trip_raw[TRIP_BELOW] = below_falling_trip_in;
    assign trip_raw[TRIP_ABOVE] = above_rising_trip_in;

    for (genvar g = 0; g < TRIP_COUNT; g++) begin : g_trip_sync
        lv_sync2 u_sync (
            .sys_clk_in (sys_clk_in),
            .rst_b_in   (rst_b_in),
            .async_in   (trip_raw[g]),
            .sync_out   (trip_sync[g])
        );
    end

    assign below_sync = trip_sync[TRIP_BELOW];
    assign above_sync = trip_sync[TRIP_ABOVE];

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic power_mode_t decode_mode(input logic [1:0] ctl);
        power_mode_t m;
        m = MODE_RUN;
        if (ctl[CTL_STOP_BIT]) begin
            m = MODE_STOP;
        end else if (ctl[CTL_WAIT_BIT]) begin
            m = MODE_WAIT;
        end
        return m;
    endfunction

    function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    typedef enum logic [1:0] {
        SEL_STATUS,
        SEL_CONFIG,
        SEL_CONTROL,
        SEL_NONE
    } reg_sel_t;

    typedef logic [3:0]  cfg_t;
    typedef logic [1:0]  ctl_t;
    typedef logic [31:0] word_t;
    localparam int WRITE_LANE = 0;

    // one decoder for both channels keeps reads and writes agreeing on the map
    function automatic reg_sel_t decode_addr(input logic [ADDR_WIDTH-1:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        if (addr_is(a, STATUS_OFFSET)) begin
            s = SEL_STATUS;
        end else if (addr_is(a, CONFIG_OFFSET)) begin
            s = SEL_CONFIG;
        end else if (addr_is(a, CONTROL_OFFSET)) begin
            s = SEL_CONTROL;
        end
        return s;
    endfunction

    function automatic word_t status_word(input logic flag, input logic act, input logic req);
        word_t w;
        w                    = '0;
        w[STATUS_FLAG_BIT]   = flag;
        w[STATUS_ACTIVE_BIT] = act;
        w[STATUS_RESET_BIT]  = req;
        return w;
    endfunction

    logic        active;
    power_mode_t mode;
    logic        do_write;
    logic        do_read;
    reg_sel_t    wr_sel;
    reg_sel_t    rd_sel;

    always_comb begin
        mode = decode_mode(state_q.ctl);
        case (mode)
            MODE_RUN:  active = state_q.cfg[CFG_ENABLE_BIT];
            MODE_WAIT: active = state_q.cfg[CFG_ENABLE_BIT];
            MODE_STOP: active = state_q.cfg[CFG_ENABLE_BIT] & ~state_q.cfg[CFG_PWRD_BIT]
                                & state_q.cfg[CFG_STOP_EN_BIT];
            default:   active = 1'b0;
        endcase
    end

    assign do_write = state_q.aw_held & state_q.w_held & ~state_q.bvalid;
    assign do_read  = s_axi_arvalid & ~state_q.rvalid;
    assign wr_sel   = decode_addr(state_q.aw_addr);
    assign rd_sel   = decode_addr(s_axi_araddr);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;

        // flag with hysteresis; falling report wins if both assert
        if (active && below_sync) begin
            state_d.flag = 1'b1;
        end else if (active && above_sync) begin
            state_d.flag = 1'b0;
        end else begin
            state_d.flag = state_q.flag;
        end

        // reset request only while monitoring and enabled
        state_d.rst_req = active & state_d.flag & state_q.cfg[CFG_RST_EN_BIT];

        // write channel capture
        if (s_axi_awvalid && !state_q.aw_held) begin
            state_d.aw_held = 1'b1;
            state_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_q.w_held) begin
            state_d.w_held = 1'b1;
            state_d.w_data = s_axi_wdata;
            state_d.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            state_d.aw_held = 1'b0;
            state_d.w_held  = 1'b0;
            state_d.bvalid  = 1'b1;
            state_d.bresp   = RESP_OKAY;
            case (wr_sel)
                SEL_CONFIG: begin
                    if (state_q.w_strb[WRITE_LANE]) begin
                        state_d.cfg = cfg_t'(state_q.w_data);
                    end
                end
                SEL_CONTROL: begin
                    if (state_q.w_strb[WRITE_LANE]) begin
                        state_d.ctl = ctl_t'(state_q.w_data);
                    end
                end
                // status is read-only: the write is dropped but still answered okay
                SEL_STATUS: begin
                    state_d.bresp = RESP_OKAY;
                end
                default: begin
                    state_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (state_q.bvalid && s_axi_bready) begin
            state_d.bvalid = 1'b0;
        end

        // a supervisor reset wakes the controller from wait or stop
        if (state_q.rst_req) begin
            state_d.ctl = CONTROL_RESET;
        end

        // read channel
        if (do_read) begin
            state_d.rvalid = 1'b1;
            state_d.rresp  = RESP_OKAY;
            state_d.rdata  = '0;
            case (rd_sel)
                SEL_STATUS: begin
                    state_d.rdata = status_word(state_q.flag, active, state_q.rst_req);
                end
                SEL_CONFIG: begin
                    state_d.rdata = word_t'(state_q.cfg);
                end
                SEL_CONTROL: begin
                    state_d.rdata = word_t'(state_q.ctl);
                end
                default: begin
                    state_d.rresp = RESP_SLVERR;
                end
            endcase
        end else if (state_q.rvalid && s_axi_rready) begin
            state_d.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            state_q <= STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // outputs; no interrupt port exists by design
    // ------------------------------------------------------------
    assign supervisor_reset_out  = state_q.rst_req;
    assign supervisor_active_out = active;
    assign s_axi_awready         = ~state_q.aw_held;
    assign s_axi_wready          = ~state_q.w_held;
    assign s_axi_bvalid          = state_q.bvalid;
    assign s_axi_bresp           = state_q.bresp;
    assign s_axi_arready         = ~state_q.rvalid;
    assign s_axi_rvalid          = state_q.rvalid;
    assign s_axi_rdata           = state_q.rdata;
    assign s_axi_rresp           = state_q.rresp;

endmodule

// >>> hdl/lv_sync2.sv
`timescale 1ns/1ps
module lv_sync2 (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    // level
    input  wire logic async_in,
    output logic      sync_out
);

    typedef struct packed {
        logic first;
        logic second;
    } sync_state_t;

    sync_state_t state_q;
    sync_state_t state_d;

    always_comb begin
        state_d.first  = async_in;
        state_d.second = state_q.first;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sync_out = state_q.second;

endmodule

// >>> inc/lv_status_pkg.sv
package lv_status_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_OFFSET  = 8'h00;
    localparam logic [7:0] CONFIG_OFFSET  = 8'h04;
    localparam logic [7:0] CONTROL_OFFSET = 8'h08;
    localparam int         ADDR_WIDTH     = 8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int STATUS_FLAG_BIT   = 0;
    localparam int STATUS_ACTIVE_BIT = 1;
    localparam int STATUS_RESET_BIT  = 2;
    localparam int CFG_ENABLE_BIT    = 0;
    localparam int CFG_RST_EN_BIT    = 1;
    localparam int CFG_PWRD_BIT      = 2;
    localparam int CFG_STOP_EN_BIT   = 3;
    localparam int CTL_WAIT_BIT      = 0;
    localparam int CTL_STOP_BIT      = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] CONFIG_RESET  = 4'h3;
    localparam logic [1:0] CONTROL_RESET = 2'h0;

    // ------------------------------------------------------------
    // axi responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_STOP
    } power_mode_t;

endpackage

// >>> verif/lv_status_sva.sv
`timescale 1ns/1ps
// ----------
// port checks
// ----------
module lv_status_sva (
    input wire logic        sys_clk_in,
    input wire logic        rst_b_in,
    input wire logic        below_falling_trip_in,
    input wire logic        above_rising_trip_in,
    input wire logic        supervisor_reset_out,
    input wire logic        supervisor_active_out,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    a_rst_clear:
    assert property ($rose(rst_b_in) |-> !supervisor_reset_out) else $error("reset request after reset");
    a_wake_src:
    assert property ($rose(supervisor_reset_out) |-> $past(supervisor_active_out)) else $error("reset while idle");
    a_clear_late:
    assert property ((above_rising_trip_in && !below_falling_trip_in) [*5] |-> !supervisor_reset_out)
        else $error("flag not cleared");
    a_mid_hold:
    assert property ((!above_rising_trip_in && !below_falling_trip_in) [*6] |-> !$rose(supervisor_reset_out))
        else $error("flag moved between thresholds");
    a_idle_quiet:
    assert property (!supervisor_active_out [*2] |-> !supervisor_reset_out) else $error("inactive but resetting");
    a_b_latency:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_r_latency:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
    a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
bind low_voltage_status_logic lv_status_sva u_sva (.sys_clk_in, .rst_b_in, .below_falling_trip_in,
    .above_rising_trip_in, .supervisor_reset_out, .supervisor_active_out, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata);

// >>> verif/lv_supply_model.sv
`timescale 1ns/1ps
// ----------
// comparator front end
// ----------
module lv_supply_model (
    // supply zone: 0 low, 1 between thresholds, 2 high
    input  wire logic [1:0] zone_in,
    // comparator levels
    output logic            below_out,
    output logic            above_out
);
    // skew keeps edges off the bus clock, as real analog outputs are unrelated to it
    assign #3 below_out = (zone_in == 2'h0);
    assign #3 above_out = (zone_in == 2'h2);
endmodule

// >>> verif/test_low_voltage_status_logic.sv
`timescale 1ns/1ps
module test_low_voltage_status_logic import lv_status_pkg::*;;
    logic        sys_clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [1:0]  zone = 2'h2;
    logic        below_falling_trip_in, above_rising_trip_in, supervisor_reset_out, supervisor_active_out;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_rsp;
    int          num_errors = 0, total_checks = 0;
    always #10 sys_clk_in = ~sys_clk_in;
    lv_supply_model u_sup (.zone_in(zone), .below_out(below_falling_trip_in), .above_out(above_rising_trip_in));
    // protection and strobes tied: the design only needs lane 0
    low_voltage_status_logic u_dut (.sys_clk_in, .rst_b_in, .below_falling_trip_in, .above_rising_trip_in,
        .supervisor_reset_out, .supervisor_active_out, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    // ----------
    // helpers
    // ----------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge sys_clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge sys_clk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid;
        end
        chk("bresp", 32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        // ready comes one edge late so the read data must hold through a stall
        s_axi_rready <= 1'b1;
        @(posedge sys_clk_in);
        rd_val = s_axi_rdata;
        rd_rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk("rdata", rd_val, e);
        chk("rresp", 32'(rd_rsp), 32'(RESP_OKAY));
    endtask
    // n edges after the zone change, then let that edge settle
    task automatic sup(input logic [1:0] z, input int n);
        @(posedge sys_clk_in);
        zone <= z;
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_regs;
        rdc(STATUS_OFFSET, 32'h2);
        rdc(CONFIG_OFFSET, 32'(CONFIG_RESET));
        rdc(CONTROL_OFFSET, 32'(CONTROL_RESET));
        rd(8'h0C);
        chk("unmapped rresp", 32'(rd_rsp), 32'(RESP_SLVERR));
        wr(8'h0C, 32'h1, RESP_SLVERR);
        wr(STATUS_OFFSET, 32'h7, RESP_OKAY);
        rdc(STATUS_OFFSET, 32'h2);
        $display("t_regs done");
    endtask
    task automatic t_low;
        sup(2'h0, 2);
        chk("reset early", 32'(supervisor_reset_out), 32'h0);
        @(posedge sys_clk_in);
        #1;
        chk("reset set", 32'(supervisor_reset_out), 32'h1);
        rdc(STATUS_OFFSET, 32'h7);
        sup(2'h1, 6);
        rdc(STATUS_OFFSET, 32'h7);
        sup(2'h2, 6);
        rdc(STATUS_OFFSET, 32'h2);
        chk("reset clear", 32'(supervisor_reset_out), 32'h0);
        $display("t_low done");
    endtask
    task automatic t_noreset;
        wr(CONFIG_OFFSET, 32'h1, RESP_OKAY);
        sup(2'h0, 6);
        rdc(STATUS_OFFSET, 32'h3);
        chk("no reset", 32'(supervisor_reset_out), 32'h0);
        sup(2'h2, 6);
        wr(CONFIG_OFFSET, 32'h3, RESP_OKAY);
        $display("t_noreset done");
    endtask
    task automatic t_wait;
        wr(CONTROL_OFFSET, 32'h1, RESP_OKAY);
        chk("wait active", 32'(supervisor_active_out), 32'h1);
        wr(CONFIG_OFFSET, 32'h0, RESP_OKAY);
        chk("wait disabled", 32'(supervisor_active_out), 32'h0);
        wr(CONFIG_OFFSET, 32'h3, RESP_OKAY);
        sup(2'h0, 6);
        chk("wait reset", 32'(supervisor_reset_out), 32'h1);
        rdc(CONTROL_OFFSET, 32'h0);
        sup(2'h2, 6);
        $display("t_wait done");
    endtask
    task automatic t_stop;
        logic        act;
        logic [31:0] ctl_w;
        for (int i = 0; i < 4; i++) begin
            act = i[1] & ~i[0];
            // odd passes ask for wait and stop at once: stop must win
            ctl_w = {30'h0, 1'h1, i[0]};
            wr(CONFIG_OFFSET, {28'h0, i[1], i[0], 2'b11}, RESP_OKAY);
            wr(CONTROL_OFFSET, ctl_w, RESP_OKAY);
            chk("stop active", 32'(supervisor_active_out), 32'(act));
            sup(2'h0, 6);
            chk("stop reset", 32'(supervisor_reset_out), 32'(act));
            rdc(CONTROL_OFFSET, act ? 32'h0 : ctl_w);
            sup(2'h2, 6);
            wr(CONTROL_OFFSET, 32'h0, RESP_OKAY);
        end
        wr(CONFIG_OFFSET, 32'h3, RESP_OKAY);
        $display("t_stop done");
    endtask
    task automatic t_sysreset;
        sup(2'h0, 6);
        sup(2'h1, 6);
        @(posedge sys_clk_in);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        rdc(STATUS_OFFSET, 32'h2);
        chk("reset gone", 32'(supervisor_reset_out), 32'h0);
        sup(2'h2, 6);
        $display("t_sysreset done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        t_regs;
        t_low;
        t_noreset;
        t_wait;
        t_stop;
        t_sysreset;
        end_sim;
    end
    // tests need about 270 cycles; the limit leaves ample margin
    initial begin
        #200us;
        num_errors++;
        end_sim;
    end
endmodule
